// *** rtl/tally_consts.svh ***
// Constants for the trigger tally and line snapshot block.
// Assumes inclusion by bare name from rtl/.
`ifndef TALLY_CONSTS_SVH
`define TALLY_CONSTS_SVH
`define TALLY_WIDTH 32
`define TALLY_START_VALUE 32'h0000_0001
`define TALLY_RESET_VALUE 32'h0000_0000
`define SNAP_WIDTH 32
`define SNAP_BIT_IN1 0
`define SNAP_BIT_IN2 1
`define SNAP_BIT_OUT1 2
`define SNAP_BIT_OUT2 3
`define ITEM_SEL_WIDTH 2
`define SRC_SEL_WIDTH 2
`define INST_SEL_WIDTH 2
`define EVT_SEL_WIDTH 2
`define INST_TRIGGER_TALLY 2'h0
`define EVT_ACQ_TRIGGER 2'h1
`endif

// *** rtl/tally_pkg.sv ***
// Types for the trigger tally and line snapshot block.
// Assumes tally_consts.svh is on the include path.
`include "tally_consts.svh"
package tally_pkg;
    typedef enum logic [1:0] {
        ITEM_NONE = 2'h0,
        ITEM_TALLY = 2'h1,
        ITEM_SNAPSHOT = 2'h2
    } item_sel_t;
    typedef enum logic [1:0] {
        CLR_OFF = 2'h0,
        CLR_LINE_ONE = 2'h1,
        CLR_LINE_TWO = 2'h2,
        CLR_SOFTWARE = 2'h3
    } clr_src_t;
    typedef enum logic [2:0] {
        CFG_IDLE = 3'b001,
        CFG_ENABLE = 3'b010,
        CFG_CLEAR = 3'b100
    } cfg_state_t;
endpackage : tally_pkg

// *** rtl/tally_if.sv ***
// Link between the tally device end and its configuring/acquisition partner.
// Assumes one clock, clk_sys, shared by both ends.
`timescale 1ns/1ps
`include "tally_consts.svh"
interface tally_if (
    input wire logic clk_sys
);
    import tally_pkg::*;
    logic metadata_append_mode_on;
    item_sel_t metadata_item_select;
    logic metadata_item_enable;
    logic item_enable_write;
    logic [`INST_SEL_WIDTH-1:0] tally_instance_select;
    logic [`EVT_SEL_WIDTH-1:0] tally_event_source;
    clr_src_t tally_clear_source;
    logic tally_clear_command;
    logic free_run_mode;
    logic acquisition_trigger_event;
    logic tally_chunk_on;
    logic snapshot_chunk_on;
    logic tally_available;
    logic chunk_valid;
    logic [`TALLY_WIDTH-1:0] trigger_tally_value;
    logic [`SNAP_WIDTH-1:0] line_level_snapshot;
    modport device (
        input metadata_append_mode_on, metadata_item_select, metadata_item_enable,
        input item_enable_write, tally_instance_select, tally_event_source,
        input tally_clear_source, tally_clear_command, free_run_mode,
        input acquisition_trigger_event,
        output tally_chunk_on, snapshot_chunk_on, tally_available, chunk_valid,
        output trigger_tally_value, line_level_snapshot
    );
    modport partner (
        output metadata_append_mode_on, metadata_item_select, metadata_item_enable,
        output item_enable_write, tally_instance_select, tally_event_source,
        output tally_clear_source, tally_clear_command, free_run_mode,
        output acquisition_trigger_event,
        input tally_chunk_on, snapshot_chunk_on, tally_available, chunk_valid,
        input trigger_tally_value, line_level_snapshot
    );
endinterface : tally_if

// *** rtl/line_sync.sv ***
// Two-stage synchroniser with rising-edge detect for one line.
// Assumes an asynchronous input pin and the system clock.
`timescale 1ns/1ps
module line_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Line
    input wire logic line_in,
    output logic level,
    output logic rise
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } sync_state_t;
    sync_state_t st_r;
    sync_state_t st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.meta = line_in;
        st_nxt.sync = st_r.meta;
        st_nxt.last = st_r.sync;
    end
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign level = st_r.sync;
    assign rise = st_r.sync & ~st_r.last;
endmodule : line_sync

// *** rtl/tally_device.sv ***
// Device end: trigger tally, clear sources, line snapshot and chunk enables.
// Assumes the partner drives the link on clk_sys; lines come from pins.
//
// Notes on behaviour
// - Tally is 32-bit unsigned, chunk appended.
// - First pass starts at one, +1 per trigger.
// - Wraps from all-ones to zero.
// - Tally unavailable in free-run mode.
// - Enabled tally chunk on every image outside free-run mode.
// - Chunk enables need global mode on first.
// - Mode off drops all item enables.
// - Select item, then set its enable.
// - Power loss returns tally to zero.
// - Clear source: line one, two, software, off.
// - Clearing disabled until a source chosen.
// - Software source clears on command only.
// - Partner selects tally instance, trigger event.
// - Tally leads frame count by one.
// - Snapshot all line levels per trigger.
// - Snapshot is a 32-bit word.
// - Bit zero for low, one for high.
// - Enabled snapshot chunk on every image.
`timescale 1ns/1ps
`include "tally_consts.svh"
module tally_device (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Partner link
    tally_if.device lnk,
    // Camera lines
    input wire logic input_line_one,
    input wire logic input_line_two,
    input wire logic output_line_one,
    input wire logic output_line_two
);
    import tally_pkg::*;

    typedef struct packed {
        logic [`TALLY_WIDTH-1:0] tally;
        logic [`SNAP_WIDTH-1:0] snap;
        logic tally_en;
        logic snap_en;
        logic valid;
        logic avail;
        logic clr_armed;
        logic trig_last;
        logic tally_chunk;
    } dev_state_t;

    dev_state_t st_r;
    dev_state_t st_nxt;
    logic in1_level;
    logic in1_rise;
    logic in2_level;
    logic in2_rise;
    // Output line levels after their own two-flop sync
    logic out1_level;
    logic out2_level;
    logic clear_now;
    logic trig_edge;

    function automatic logic [`SNAP_WIDTH-1:0] pack_lines(
        input logic i1,
        input logic i2,
        input logic o1,
        input logic o2
    );
        logic [`SNAP_WIDTH-1:0] w;
        w = '0;
        w[`SNAP_BIT_IN1] = i1;
        w[`SNAP_BIT_IN2] = i2;
        w[`SNAP_BIT_OUT1] = o1;
        w[`SNAP_BIT_OUT2] = o2;
        // Unmapped bits were cleared above and read as zero
        return w;
    endfunction : pack_lines

    // Enable write aimed at one item; refused while mode is off
    function automatic logic item_hit(
        input logic wr,
        input logic mode,
        input item_sel_t sel,
        input item_sel_t want
    );
        return wr && mode && (sel == want);
    endfunction : item_hit

    ////////////////////////////////////////////////////////////////////////
    // line edge sync
    line_sync u_sync_one (
        .clk_sys(clk_sys),
        .reset(reset),
        .line_in(input_line_one),
        .level(in1_level),
        .rise(in1_rise)
    );
    line_sync u_sync_two (
        .clk_sys(clk_sys),
        .reset(reset),
        .line_in(input_line_two),
        .level(in2_level),
        .rise(in2_rise)
    );

    // Output lines are read back as pins, so they cross domains too
    line_sync u_sync_out_one (
        .clk_sys(clk_sys),
        .reset(reset),
        .line_in(output_line_one),
        .level(out1_level),
        .rise()
    );
    line_sync u_sync_out_two (
        .clk_sys(clk_sys),
        .reset(reset),
        .line_in(output_line_two),
        .level(out2_level),
        .rise()
    );

    ////////////////////////////////////////////////////////////////////////
    // Trigger pulse is same-domain; edge guards a held level
    assign trig_edge = lnk.acquisition_trigger_event & ~st_r.trig_last;

    // Line clears are edges, so a held line clears once
    // clear source select
    always_comb
    begin
        unique case (lnk.tally_clear_source)
            CLR_LINE_ONE: clear_now = in1_rise;
            CLR_LINE_TWO: clear_now = in2_rise;
            CLR_SOFTWARE: clear_now = lnk.tally_clear_command;
            default: clear_now = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: enables, tally, snapshot
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.trig_last = lnk.acquisition_trigger_event;
        st_nxt.valid = 1'b0;
        // Qualifier lags a selection change by one cycle
        // Only tally instance counting triggers is clearable here
        st_nxt.clr_armed = (lnk.tally_instance_select == `INST_TRIGGER_TALLY)
            && (lnk.tally_event_source == `EVT_ACQ_TRIGGER);
        st_nxt.avail = ~lnk.free_run_mode;
        if (item_hit(lnk.item_enable_write, lnk.metadata_append_mode_on,
            lnk.metadata_item_select, ITEM_TALLY))
            st_nxt.tally_en = lnk.metadata_item_enable;
        if (item_hit(lnk.item_enable_write, lnk.metadata_append_mode_on,
            lnk.metadata_item_select, ITEM_SNAPSHOT))
            st_nxt.snap_en = lnk.metadata_item_enable;
        if (!lnk.metadata_append_mode_on)
        begin
            st_nxt.tally_en = 1'b0;
            st_nxt.snap_en = 1'b0;
        end
        // Plain add: all-ones rolls over to zero
        // count and wrap
        if (trig_edge && !lnk.free_run_mode)
            st_nxt.tally = st_r.tally + `TALLY_WIDTH'(1);
        // Clear beats a same-cycle trigger; next trigger reads one again
        if (clear_now && st_r.clr_armed)
            st_nxt.tally = `TALLY_RESET_VALUE;
        // Taken in free run too; only the tally stops
        // snapshot at trigger
        if (trig_edge)
        begin
            st_nxt.snap = pack_lines(in1_level, in2_level, out1_level, out2_level);
            st_nxt.valid = 1'b1;
        end
        // Registered so the chunk flag leaves straight from a flop
        st_nxt.tally_chunk = st_nxt.tally_en & st_nxt.avail;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.tally <= `TALLY_RESET_VALUE;
        end
        else
            st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Every output leaves straight from a flop
    // tally chunk out
    assign lnk.trigger_tally_value = st_r.tally;
    assign lnk.line_level_snapshot = st_r.snap;
    assign lnk.tally_chunk_on = st_r.tally_chunk;
    assign lnk.snapshot_chunk_on = st_r.snap_en;
    assign lnk.tally_available = st_r.avail;
    assign lnk.chunk_valid = st_r.valid;
endmodule : tally_device

// *** rtl/tally_partner.sv ***
// Partner end: configures chunks and clearing, forwards triggers.
// Assumes user-side requests are one-cycle pulses on clk_sys.
`timescale 1ns/1ps
`include "tally_consts.svh"
module tally_partner (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Partner link
    tally_if.partner lnk,
    // User requests
    input wire logic mode_on_req,
    input wire logic mode_off_req,
    input wire tally_pkg::item_sel_t item_req,
    input wire logic item_on,
    input wire logic item_req_valid,
    input wire tally_pkg::clr_src_t clr_src_req,
    input wire logic clr_src_valid,
    input wire logic clr_cmd_req,
    input wire logic free_run,
    input wire logic trigger_in,
    // User results
    output logic [`TALLY_WIDTH-1:0] tally_out,
    output logic [`SNAP_WIDTH-1:0] snapshot_out,
    output logic tally_chunk_out,
    output logic snapshot_chunk_out,
    output logic result_valid,
    output logic busy
);
    import tally_pkg::*;

    typedef struct packed {
        cfg_state_t state;
        logic mode;
        item_sel_t sel;
        logic en;
        logic wr;
        clr_src_t src;
        logic clr;
        logic free;
        logic trig;
        logic [`TALLY_WIDTH-1:0] tally;
        logic [`SNAP_WIDTH-1:0] snap;
        logic tch;
        logic sch;
        logic vld;
        logic busy;
    } part_state_t;

    part_state_t st_r;
    part_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.wr = 1'b0;
        st_nxt.clr = 1'b0;
        st_nxt.trig = trigger_in;
        st_nxt.free = free_run;
        st_nxt.vld = lnk.chunk_valid;
        if (lnk.chunk_valid)
        begin
            st_nxt.tally = lnk.trigger_tally_value;
            st_nxt.snap = lnk.line_level_snapshot;
            st_nxt.tch = lnk.tally_chunk_on;
            st_nxt.sch = lnk.snapshot_chunk_on;
        end
        if (mode_on_req)
            st_nxt.mode = 1'b1;
        else if (mode_off_req)
            st_nxt.mode = 1'b0;
        if (clr_src_valid)
            st_nxt.src = clr_src_req;
        unique case (st_r.state)
            CFG_IDLE:
            begin
                if (item_req_valid && st_r.mode)
                begin
                    st_nxt.sel = item_req;
                    st_nxt.en = item_on;
                    st_nxt.state = CFG_ENABLE;
                end
                else if (clr_cmd_req)
                    st_nxt.state = CFG_CLEAR;
            end
            CFG_ENABLE:
            begin
                st_nxt.wr = st_r.mode;
                st_nxt.state = CFG_IDLE;
            end
            CFG_CLEAR:
            begin
                st_nxt.clr = (st_r.src == CLR_SOFTWARE);
                st_nxt.state = CFG_IDLE;
            end
            default: st_nxt.state = CFG_IDLE;
        endcase
        st_nxt.busy = (st_nxt.state != CFG_IDLE);
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.state <= CFG_IDLE;
            st_r.sel <= ITEM_NONE;
            st_r.src <= CLR_OFF;
        end
        else
            st_r <= st_nxt;
    end

    assign lnk.metadata_append_mode_on = st_r.mode;
    assign lnk.metadata_item_select = st_r.sel;
    assign lnk.metadata_item_enable = st_r.en;
    assign lnk.item_enable_write = st_r.wr;
    assign lnk.tally_instance_select = `INST_TRIGGER_TALLY;
    assign lnk.tally_event_source = `EVT_ACQ_TRIGGER;
    assign lnk.tally_clear_source = st_r.src;
    assign lnk.tally_clear_command = st_r.clr;
    assign lnk.free_run_mode = st_r.free;
    assign lnk.acquisition_trigger_event = st_r.trig;
    assign tally_out = st_r.tally;
    assign snapshot_out = st_r.snap;
    assign tally_chunk_out = st_r.tch;
    assign snapshot_chunk_out = st_r.sch;
    assign result_valid = st_r.vld;
    assign busy = st_r.busy;
endmodule : tally_partner

// *** bench/tally_link_properties.sv ***
// Concurrent checks on the link between the device and partner ends.
// Assumes one clock domain; instantiated by tb beside the link.
`timescale 1ns/1ps
`include "tally_consts.svh"
module tally_link_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Link, partner side
    input wire logic metadata_append_mode_on,
    input wire tally_pkg::item_sel_t metadata_item_select,
    input wire logic metadata_item_enable,
    input wire logic item_enable_write,
    input wire logic [`INST_SEL_WIDTH-1:0] tally_instance_select,
    input wire logic [`EVT_SEL_WIDTH-1:0] tally_event_source,
    input wire tally_pkg::clr_src_t tally_clear_source,
    input wire logic tally_clear_command,
    input wire logic free_run_mode,
    input wire logic acquisition_trigger_event,
    // Link, device side
    input wire logic tally_chunk_on,
    input wire logic snapshot_chunk_on,
    input wire logic chunk_valid,
    input wire logic tally_available,
    input wire logic [`TALLY_WIDTH-1:0] trigger_tally_value,
    input wire logic [`SNAP_WIDTH-1:0] line_level_snapshot
);
    import tally_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////
    // Edge of the trigger as the device takes it
    logic trig_d_r;
    always_ff @(posedge clk_sys)
    begin
        trig_d_r <= acquisition_trigger_event;
    end
    wire take = acquisition_trigger_event && !trig_d_r;
    wire src_off = tally_clear_source == CLR_OFF;
    ////////////////////////////////////////////////////////////////////////////
    count_step_a: assert property (take && !free_run_mode && src_off
        |=> trigger_tally_value == $past(trigger_tally_value) + 32'h1)
        else $error("tally did not advance by one");
    valid_pulse_a: assert property (take |=> chunk_valid ##1 !chunk_valid)
        else $error("no single chunk pulse after trigger");
    valid_cause_a: assert property (chunk_valid |-> $past(take))
        else $error("chunk pulse without trigger");
    free_hold_a: assert property (take && free_run_mode && src_off
        |=> $stable(trigger_tally_value))
        else $error("tally counted in free run");
    free_chunk_a: assert property (free_run_mode |=> !tally_chunk_on)
        else $error("tally chunk on in free run");
    avail_on_a: assert property (!free_run_mode |=> tally_available)
        else $error("tally unavailable outside free run");
    mode_off_a: assert property (!metadata_append_mode_on
        |=> !tally_chunk_on && !snapshot_chunk_on)
        else $error("chunk enable survived mode off");
    enable_set_a: assert property (item_enable_write && metadata_append_mode_on
        && metadata_item_select == ITEM_SNAPSHOT
        |=> snapshot_chunk_on == $past(metadata_item_enable))
        else $error("snapshot enable write not taken");
    sw_clear_a: assert property (tally_clear_command
        && tally_clear_source == CLR_SOFTWARE && $past(tally_clear_source) == CLR_SOFTWARE
        && $past(tally_instance_select) == `INST_TRIGGER_TALLY
        && $past(tally_event_source) == `EVT_ACQ_TRIGGER
        |=> trigger_tally_value == `TALLY_RESET_VALUE)
        else $error("software clear ignored");
    off_still_a: assert property (src_off && $past(src_off) && !take
        |=> $stable(trigger_tally_value))
        else $error("tally changed with clearing off");
    spare_zero_a: assert property (line_level_snapshot[31:4] == 28'h0000000)
        else $error("spare snapshot bits set");
endmodule : tally_link_checker

// *** bench/tb.sv ***
// Bench joining the partner and device ends; drives the partner's user side.
// Assumes rtl/ compiled first; lines are driven straight onto the device pins.
`timescale 1ns/1ps
`include "tally_consts.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected at %0t: got %0h want %0h", $time, got, exp); end end
module tb;
    import tally_pkg::*;
    typedef struct {logic [3:0] ln; logic fr; logic [31:0] tally;} row_t;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic mode_on_req = 1'b0, mode_off_req = 1'b0, item_on = 1'b0, item_req_valid = 1'b0;
    logic clr_src_valid = 1'b0, clr_cmd_req = 1'b0, free_run = 1'b0, trigger_in = 1'b0;
    item_sel_t item_req = ITEM_NONE;
    clr_src_t clr_src_req = CLR_OFF;
    logic [3:0] lines = 4'h0;
    logic [31:0] tally_out, snapshot_out;
    logic tally_chunk_out, snapshot_chunk_out, result_valid, busy;
    int err_count = 0;
    int samples_checked = 0;
    // Lines: bit 0 in1, 1 in2, 2 out1, 3 out2
    row_t rows [5] = '{'{4'h0, 1'b0, 32'h1}, '{4'h5, 1'b0, 32'h2}, '{4'hA, 1'b0, 32'h3},
        '{4'hF, 1'b1, 32'h3}, '{4'h3, 1'b0, 32'h4}};
    always #4 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    tally_if lnk (.clk_sys(clk_sys));
    tally_device tally_device_inst (.clk_sys(clk_sys), .reset(reset), .lnk(lnk),
        .input_line_one(lines[0]), .input_line_two(lines[1]),
        .output_line_one(lines[2]), .output_line_two(lines[3]));
    tally_partner tally_partner_inst (.clk_sys(clk_sys), .reset(reset), .lnk(lnk),
        .mode_on_req(mode_on_req), .mode_off_req(mode_off_req), .item_req(item_req),
        .item_on(item_on), .item_req_valid(item_req_valid), .clr_src_req(clr_src_req),
        .clr_src_valid(clr_src_valid), .clr_cmd_req(clr_cmd_req), .free_run(free_run),
        .trigger_in(trigger_in), .tally_out(tally_out), .snapshot_out(snapshot_out),
        .tally_chunk_out(tally_chunk_out), .snapshot_chunk_out(snapshot_chunk_out),
        .result_valid(result_valid), .busy(busy));
    tally_link_checker tally_link_checker_inst (.clk_sys(clk_sys), .reset(reset),
        .metadata_append_mode_on(lnk.metadata_append_mode_on),
        .metadata_item_select(lnk.metadata_item_select),
        .metadata_item_enable(lnk.metadata_item_enable),
        .item_enable_write(lnk.item_enable_write),
        .tally_instance_select(lnk.tally_instance_select),
        .tally_event_source(lnk.tally_event_source),
        .tally_clear_source(lnk.tally_clear_source),
        .tally_clear_command(lnk.tally_clear_command), .free_run_mode(lnk.free_run_mode),
        .acquisition_trigger_event(lnk.acquisition_trigger_event),
        .tally_chunk_on(lnk.tally_chunk_on), .snapshot_chunk_on(lnk.snapshot_chunk_on),
        .tally_available(lnk.tally_available),
        .chunk_valid(lnk.chunk_valid), .trigger_tally_value(lnk.trigger_tally_value),
        .line_level_snapshot(lnk.line_level_snapshot));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] snap(input logic [3:0] ln);
        snap = 32'h0;
        snap[`SNAP_BIT_IN1] = ln[0];
        snap[`SNAP_BIT_IN2] = ln[1];
        snap[`SNAP_BIT_OUT1] = ln[2];
        snap[`SNAP_BIT_OUT2] = ln[3];
    endfunction : snap
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic req_item(input item_sel_t s, input logic on);
        item_req = s;
        item_on = on;
        item_req_valid = 1'b1;
        cyc(1);
        item_req_valid = 1'b0;
        cyc(6);
    endtask : req_item
    task automatic set_src(input clr_src_t s);
        clr_src_req = s;
        clr_src_valid = 1'b1;
        cyc(1);
        clr_src_valid = 1'b0;
        cyc(6);
    endtask : set_src
    task automatic pulse_mode(input logic on);
        mode_on_req = on;
        mode_off_req = !on;
        cyc(1);
        mode_on_req = 1'b0;
        mode_off_req = 1'b0;
        cyc(4);
    endtask : pulse_mode
    // Lines settle past the two-flop sync before the trigger
    task automatic trig(input logic [3:0] ln, input logic fr);
        int k;
        lines = ln;
        free_run = fr;
        cyc(6);
        trigger_in = 1'b1;
        cyc(1);
        trigger_in = 1'b0;
        k = 0;
        while (result_valid !== 1'b1 && k < 20)
        begin
            cyc(1);
            k++;
        end
        if (k == 20)
        begin
            err_count++;
            $display("unexpected at %0t: no result", $time);
        end
    endtask : trig
    task automatic summarize();
        if (err_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #40000;
        err_count++;
        summarize();
    end
    initial
    begin
        cyc(4);
        reset = 1'b0;
        cyc(1);
        `CHK(tally_out, 32'h0)
        `CHK(busy, 1'b0)
        // Item enable is refused before mode on; free run keeps the tally at zero
        req_item(ITEM_SNAPSHOT, 1'b1);
        trig(4'h0, 1'b1);
        `CHK(snapshot_chunk_out, 1'b0)
        `CHK(tally_out, 32'h0)
        pulse_mode(1'b1);
        req_item(ITEM_TALLY, 1'b1);
        req_item(ITEM_SNAPSHOT, 1'b1);
        foreach (rows[i])
        begin
            trig(rows[i].ln, rows[i].fr);
            `CHK(tally_out, rows[i].tally)
            `CHK(snapshot_out, snap(rows[i].ln))
            `CHK(tally_chunk_out, !rows[i].fr)
            `CHK(tally_chunk_out | rows[i].fr, 1'b1)
            `CHK(snapshot_chunk_out, 1'b1)
        end
        set_src(CLR_SOFTWARE);
        clr_cmd_req = 1'b1;
        cyc(1);
        clr_cmd_req = 1'b0;
        cyc(6);
        trig(4'h0, 1'b0);
        `CHK(tally_out, 32'h1)
        for (int i = 0; i < 2; i++)
        begin
            set_src(i == 0 ? CLR_LINE_ONE : CLR_LINE_TWO);
            lines[i] = 1'b1;
            cyc(6);
            trig(4'h0, 1'b0);
            `CHK(tally_out, 32'h1)
        end
        set_src(CLR_OFF);
        lines[0] = 1'b1;
        cyc(6);
        trig(4'h0, 1'b0);
        `CHK(tally_out, 32'h2)
        pulse_mode(1'b0);
        trig(4'h0, 1'b0);
        `CHK(tally_out, 32'h3)
        `CHK(tally_chunk_out, 1'b0)
        `CHK(snapshot_chunk_out, 1'b0)
        reset = 1'b1;
        cyc(4);
        reset = 1'b0;
        cyc(1);
        `CHK(tally_out, 32'h0)
        trig(4'h0, 1'b0);
        `CHK(tally_out, 32'h1)
        summarize();
    end
endmodule : tb
